//--- logic/apmd_pkg.sv
package apmd_pkg;
   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_ACCEL_X_LOW = 8'h02;
   localparam logic [7:0] ADDR_ACCEL_X_HIGH = 8'h03;
   localparam logic [7:0] ADDR_ACCEL_Y_LOW = 8'h04;
   localparam logic [7:0] ADDR_ACCEL_Y_HIGH = 8'h05;
   localparam logic [7:0] ADDR_ACCEL_Z_LOW = 8'h06;
   localparam logic [7:0] ADDR_ACCEL_Z_HIGH = 8'h07;
   localparam logic [7:0] ADDR_FILTER_BANDWIDTH = 8'h10;
   localparam logic [7:0] ADDR_LOW_POWER_CONTROL = 8'h11;
   localparam logic [7:0] ADDR_LOW_POWER_SELECT = 8'h12;
   localparam logic [7:0] ADDR_DATA_PATH_CONFIG = 8'h13;
   localparam logic [7:0] ADDR_SOFT_RESET_CMD = 8'h14;
   localparam logic [7:0] ADDR_IRQ_PIN_ELECTRICAL = 8'h20;
   localparam logic [7:0] ADDR_SERIAL_WATCHDOG_CONFIG = 8'h34;
   // ------------------------------------------------------------
   // Field positions and values
   // ------------------------------------------------------------
   localparam int BIT_SUSPEND = 7;
   localparam int BIT_LOWPOWER_EN = 6;
   localparam int BIT_DEEP_SUSPEND = 5;
   localparam int BIT_LOWPOWER_MODE = 6;
   localparam int BIT_RAW_STREAM_SELECT = 7;
   localparam int BIT_SHADOW_DISABLE = 6;
   localparam logic [7:0] SOFT_RESET_KEY = 8'hB6;
   localparam logic [7:0] RESET_FILTER_BANDWIDTH = 8'h0F;
   localparam logic [7:0] RESET_ZERO = 8'h00;
   localparam logic [7:0] WATCHDOG_MASK = 8'h06;
   localparam logic [7:0] IRQ_PIN_MASK = 8'h0F;
   localparam logic [7:0] LPC_KEEP_MASK = 8'h20;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_MHZ = 200;
   localparam int RAW_PERIOD_US = 500;
   localparam int RAW_PERIOD_CYC = RAW_PERIOD_US * CLK_MHZ;
   localparam int SUSPEND_WRITE_GAP_US = 450;
   localparam int SUSPEND_WRITE_GAP_CYC = SUSPEND_WRITE_GAP_US * CLK_MHZ;
   // Sleep durations in 0.5 ms units
   localparam int SLEEP_UNIT_US = 500;

   typedef enum logic [2:0] {
      APMD_NORMAL = 3'b000,
      APMD_STANDBY = 3'b001,
      APMD_SUSPEND = 3'b010,
      APMD_DEEP_SUSPEND = 3'b011,
      APMD_LOW_POWER1 = 3'b100,
      APMD_LOW_POWER2 = 3'b101
   } apmd_mode_t;

   typedef struct packed {
      logic [13:0] x;
      logic [13:0] y;
      logic [13:0] z;
   } apmd_sample_t;

   typedef struct packed {
      logic read;
      logic write;
      logic [7:0] addr;
      logic [7:0] wdata;
   } apmd_req_t;
endpackage

//--- logic/apmd_top.sv
`timescale 1ns/1ps
// Summary of operation
// - Reset leaves device in normal mode, sampling
// - Standby stops acquisition, keeps data and config
// - Mode decoded from four control bits
// - Suspend stops acquisition, keeps data, accepts access
// - Deep suspend loses config; host rewrites settings
// - Watchdog, deep-suspend and pin bits survive
// - Deep suspend toggled only while suspend clear
// - Writing key to reset register restores defaults
// - Low power 1 alternates wake and suspend-like sleep
// - Low power 2 alternates wake and standby-like sleep
// - Wake lasts for samples, interrupts, open access
// - Four-bit code selects sleep duration
// - Fourteen-bit samples split high and low bytes
// - Axis bytes mapped at fixed offsets
// - Low read freezes high byte when shadowing
// - New-data flag set on update, cleared on read
// - Raw at 2 kHz, filtered at twice bandwidth
// - Select bit picks filtered or raw stream
// - Both streams offset-corrected before storing
// - Bandwidth code sets filtered rate, reserved folded
// - Power-on reset restores all defaults
module apmd_top
   import apmd_pkg::*;
#(
   parameter int RAW_PERIOD = RAW_PERIOD_CYC,
   parameter int SLEEP_UNIT = SLEEP_UNIT_US * CLK_MHZ,
   parameter int WAKE_SAMPLES = 1
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire apmd_req_t req_in,
   input wire logic access_busy_in,
   input wire logic irq_hold_in,
   input wire apmd_sample_t raw_sample_in,
   input wire apmd_sample_t filt_sample_in,
   input wire apmd_sample_t offset_in,
   output logic [7:0] rdata_out,
   output logic rvalid_out,
   output logic analog_on_out,
   output logic acquiring_out,
   output apmd_mode_t mode_out,
   output logic [3:0] irq_pin_config_out,
   output logic [1:0] watchdog_config_out
);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] sleep_units(input logic [3:0] code);
      case (code)
         4'h6: sleep_units = 32'd2;
         4'h7: sleep_units = 32'd4;
         4'h8: sleep_units = 32'd8;
         4'h9: sleep_units = 32'd12;
         4'hA: sleep_units = 32'd20;
         4'hB: sleep_units = 32'd50;
         4'hC: sleep_units = 32'd100;
         4'hD: sleep_units = 32'd200;
         4'hE: sleep_units = 32'd1000;
         4'hF: sleep_units = 32'd2000;
         default: sleep_units = 32'd1;
      endcase
   endfunction

   // Filtered period in raw periods; 64 ms down to 0.5 ms
   function automatic logic [7:0] filt_div(input logic [4:0] bw);
      if (bw[4]) begin
         filt_div = 8'd1;
      end else if (!bw[3]) begin
         filt_div = 8'd128;
      end else begin
         filt_div = 8'h80 >> bw[2:0];
      end
   endfunction

   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   logic [7:0] filter_bandwidth;
   logic [7:0] low_power_control;
   logic [7:0] low_power_select;
   logic [7:0] data_path_config;
   logic [7:0] irq_pin_electrical;
   logic [7:0] serial_watchdog_config;
   logic soft_reset;
   logic wr_lpc;
   logic deep_now;
   apmd_mode_t mode;

   assign soft_reset = req_in.write && req_in.addr == ADDR_SOFT_RESET_CMD &&
                       req_in.wdata == SOFT_RESET_KEY;
   assign wr_lpc = req_in.write && req_in.addr == ADDR_LOW_POWER_CONTROL;
   assign deep_now = mode == APMD_DEEP_SUSPEND;

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         low_power_control <= RESET_ZERO;
      end else if (soft_reset) begin
         low_power_control <= RESET_ZERO;
      end else if (wr_lpc) begin
         if (low_power_control[BIT_SUSPEND] || req_in.wdata[BIT_SUSPEND]) begin
            // Deep-suspend bit kept while suspend is set
            low_power_control <= (req_in.wdata & ~LPC_KEEP_MASK) |
                                 (low_power_control & LPC_KEEP_MASK);
         end else if (deep_now) begin
            low_power_control <= req_in.wdata & LPC_KEEP_MASK;
         end else begin
            low_power_control <= req_in.wdata;
         end
      end
   end

   // Lost in deep suspend, restored to defaults on every entry
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         filter_bandwidth <= RESET_FILTER_BANDWIDTH;
         low_power_select <= RESET_ZERO;
         data_path_config <= RESET_ZERO;
      end else if (soft_reset || deep_now) begin
         filter_bandwidth <= RESET_FILTER_BANDWIDTH;
         low_power_select <= RESET_ZERO;
         data_path_config <= RESET_ZERO;
      end else if (req_in.write) begin
         if (req_in.addr == ADDR_FILTER_BANDWIDTH) begin
            filter_bandwidth <= {3'b000, req_in.wdata[4:0]};
         end else if (req_in.addr == ADDR_LOW_POWER_SELECT) begin
            low_power_select <= req_in.wdata & 8'h40;
         end else if (req_in.addr == ADDR_DATA_PATH_CONFIG) begin
            data_path_config <= req_in.wdata & 8'hC0;
         end
      end
   end

   // Survive deep suspend
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         irq_pin_electrical <= RESET_ZERO;
         serial_watchdog_config <= RESET_ZERO;
      end else if (soft_reset) begin
         irq_pin_electrical <= RESET_ZERO;
         serial_watchdog_config <= RESET_ZERO;
      end else if (req_in.write) begin
         if (req_in.addr == ADDR_IRQ_PIN_ELECTRICAL) begin
            irq_pin_electrical <= req_in.wdata & IRQ_PIN_MASK;
         end else if (req_in.addr == ADDR_SERIAL_WATCHDOG_CONFIG) begin
            serial_watchdog_config <= req_in.wdata & WATCHDOG_MASK;
         end
      end
   end

   // ------------------------------------------------------------
   // Mode decode
   // ------------------------------------------------------------
   always_comb begin
      case ({low_power_control[BIT_SUSPEND], low_power_control[BIT_LOWPOWER_EN],
             low_power_control[BIT_DEEP_SUSPEND], low_power_select[BIT_LOWPOWER_MODE]})
         4'b1001: mode = APMD_STANDBY;
         4'b1000: mode = APMD_SUSPEND;
         4'b0010: mode = APMD_DEEP_SUSPEND;
         4'b0100: mode = APMD_LOW_POWER1;
         4'b0101: mode = APMD_LOW_POWER2;
         default: mode = APMD_NORMAL;
      endcase
   end

   // ------------------------------------------------------------
   // Sample timing and duty cycle
   // ------------------------------------------------------------
   logic [31:0] raw_count;
   logic raw_tick;
   logic [7:0] filt_count;
   logic filt_tick;
   logic sleeping;
   logic [31:0] sleep_count;
   logic [7:0] wake_count;
   logic lp_mode;
   logic acquiring;
   logic sample_tick;

   assign lp_mode = mode == APMD_LOW_POWER1 || mode == APMD_LOW_POWER2;
   assign acquiring = mode == APMD_NORMAL || (lp_mode && !sleeping);
   assign raw_tick = raw_count == 32'(RAW_PERIOD - 1);
   assign filt_tick = raw_tick && filt_count == filt_div(filter_bandwidth[4:0]) - 8'd1;
   assign sample_tick = acquiring && (data_path_config[BIT_RAW_STREAM_SELECT] ? raw_tick : filt_tick);

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         raw_count <= '0;
         filt_count <= '0;
      end else if (!acquiring) begin
         raw_count <= '0;
         filt_count <= '0;
      end else if (raw_tick) begin
         raw_count <= '0;
         filt_count <= filt_tick ? 8'd0 : filt_count + 8'd1;
      end else begin
         raw_count <= raw_count + 32'd1;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sleeping <= 1'b0;
         sleep_count <= '0;
         wake_count <= '0;
      end else if (!lp_mode) begin
         sleeping <= 1'b0;
         sleep_count <= '0;
         wake_count <= '0;
      end else if (sleeping) begin
         if (sleep_count >= sleep_units(low_power_control[4:1]) * 32'(SLEEP_UNIT) - 32'd1) begin
            sleeping <= 1'b0;
            sleep_count <= '0;
         end else begin
            sleep_count <= sleep_count + 32'd1;
         end
      end else begin
         if (sample_tick && wake_count < 8'(WAKE_SAMPLES)) begin
            wake_count <= wake_count + 8'd1;
         end
         if (wake_count >= 8'(WAKE_SAMPLES) && !access_busy_in && !irq_hold_in) begin
            sleeping <= 1'b1;
            wake_count <= '0;
         end
      end
   end

   // ------------------------------------------------------------
   // Data registers with shadowing
   // ------------------------------------------------------------
   logic [13:0] axis_data [3];
   logic [7:0] high_shadow [3];
   logic [2:0] locked;
   logic [2:0] new_data;
   apmd_sample_t corrected;

   assign corrected.x = (data_path_config[BIT_RAW_STREAM_SELECT] ? raw_sample_in.x : filt_sample_in.x) +
                        offset_in.x;
   assign corrected.y = (data_path_config[BIT_RAW_STREAM_SELECT] ? raw_sample_in.y : filt_sample_in.y) +
                        offset_in.y;
   assign corrected.z = (data_path_config[BIT_RAW_STREAM_SELECT] ? raw_sample_in.z : filt_sample_in.z) +
                        offset_in.z;

   for (genvar a = 0; a < 3; a++) begin : g_axis
      logic [13:0] fresh;
      logic rd_low;
      logic rd_high;
      assign fresh = a == 0 ? corrected.x : (a == 1 ? corrected.y : corrected.z);
      assign rd_low = req_in.read && req_in.addr == ADDR_ACCEL_X_LOW + 8'(2 * a);
      assign rd_high = req_in.read && req_in.addr == ADDR_ACCEL_X_HIGH + 8'(2 * a);
      always_ff @(posedge clk_in or negedge resetn_in) begin
         if (!resetn_in) begin
            axis_data[a] <= '0;
            high_shadow[a] <= '0;
            locked[a] <= 1'b0;
         end else begin
            if (sample_tick) begin
               axis_data[a] <= fresh;
            end
            if (rd_low && !locked[a] && !data_path_config[BIT_SHADOW_DISABLE]) begin
               locked[a] <= 1'b1;
               high_shadow[a] <= axis_data[a][13:6];
            end else if (rd_high || data_path_config[BIT_SHADOW_DISABLE]) begin
               locked[a] <= 1'b0;
            end
         end
      end
      always_ff @(posedge clk_in or negedge resetn_in) begin
         if (!resetn_in) begin
            new_data[a] <= 1'b0;
         end else if (sample_tick) begin
            new_data[a] <= 1'b1;
         end else if (rd_low || rd_high) begin
            new_data[a] <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Read port
   // ------------------------------------------------------------
   logic [7:0] next_rdata;
   logic [1:0] axis_sel;
   assign axis_sel = 2'((req_in.addr - ADDR_ACCEL_X_LOW) >> 1);

   always_comb begin
      next_rdata = RESET_ZERO;
      if (req_in.addr >= ADDR_ACCEL_X_LOW && req_in.addr <= ADDR_ACCEL_Z_HIGH) begin
         if (!req_in.addr[0]) begin
            next_rdata = {axis_data[axis_sel][5:0], 1'b0, new_data[axis_sel]};
         end else if (locked[axis_sel]) begin
            next_rdata = high_shadow[axis_sel];
         end else begin
            next_rdata = axis_data[axis_sel][13:6];
         end
      end else if (req_in.addr == ADDR_FILTER_BANDWIDTH) begin
         next_rdata = filter_bandwidth;
      end else if (req_in.addr == ADDR_LOW_POWER_CONTROL) begin
         next_rdata = low_power_control;
      end else if (req_in.addr == ADDR_LOW_POWER_SELECT) begin
         next_rdata = low_power_select;
      end else if (req_in.addr == ADDR_DATA_PATH_CONFIG) begin
         next_rdata = data_path_config;
      end else if (req_in.addr == ADDR_IRQ_PIN_ELECTRICAL) begin
         next_rdata = irq_pin_electrical;
      end else if (req_in.addr == ADDR_SERIAL_WATCHDOG_CONFIG) begin
         next_rdata = serial_watchdog_config;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rdata_out <= '0;
         rvalid_out <= 1'b0;
      end else begin
         rdata_out <= req_in.read ? next_rdata : rdata_out;
         rvalid_out <= req_in.read;
      end
   end

   // ------------------------------------------------------------
   // Status outputs
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         analog_on_out <= 1'b0;
         acquiring_out <= 1'b0;
         mode_out <= APMD_NORMAL;
         irq_pin_config_out <= '0;
         watchdog_config_out <= '0;
      end else begin
         analog_on_out <= acquiring;
         acquiring_out <= acquiring;
         mode_out <= mode;
         irq_pin_config_out <= irq_pin_electrical[3:0];
         watchdog_config_out <= serial_watchdog_config[2:1];
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_soft_reset;
      @(posedge clk_in) disable iff (!resetn_in)
      soft_reset |=> mode == APMD_NORMAL && low_power_control == RESET_ZERO;
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("Soft reset missed");

   property p_standby_idle;
      @(posedge clk_in) disable iff (!resetn_in)
      mode == APMD_STANDBY |-> !sample_tick;
   endproperty
   a_standby_idle: assert property (p_standby_idle) else $error("Standby sampled");

   property p_suspend_idle;
      @(posedge clk_in) disable iff (!resetn_in)
      mode == APMD_SUSPEND |=> !acquiring_out;
   endproperty
   a_suspend_idle: assert property (p_suspend_idle) else $error("Suspend acquiring");

   property p_deep_lock;
      @(posedge clk_in) disable iff (!resetn_in)
      wr_lpc && !soft_reset && low_power_control[BIT_SUSPEND] |=>
         $stable(low_power_control[BIT_DEEP_SUSPEND]);
   endproperty
   a_deep_lock: assert property (p_deep_lock) else $error("Deep bit moved under suspend");

   property p_deep_clears;
      @(posedge clk_in) disable iff (!resetn_in)
      deep_now ##1 deep_now |-> data_path_config == RESET_ZERO && filter_bandwidth == RESET_FILTER_BANDWIDTH;
   endproperty
   a_deep_clears: assert property (p_deep_clears) else $error("Config kept in deep suspend");

   property p_new_data;
      @(posedge clk_in) disable iff (!resetn_in)
      sample_tick |=> new_data == 3'b111;
   endproperty
   a_new_data: assert property (p_new_data) else $error("New-data flag not set");

   property p_shadow;
      @(posedge clk_in) disable iff (!resetn_in)
      locked[0] && !(req_in.read && req_in.addr == ADDR_ACCEL_X_HIGH) && !data_path_config[BIT_SHADOW_DISABLE]
         |=> $stable(high_shadow[0]);
   endproperty
   a_shadow: assert property (p_shadow) else $error("Shadowed high byte changed");

   property p_raw_rate;
      @(posedge clk_in) disable iff (!resetn_in)
      raw_tick |=> raw_count == 32'd0;
   endproperty
   a_raw_rate: assert property (p_raw_rate) else $error("Raw period wrong");

   property p_sleep_no_sample;
      @(posedge clk_in) disable iff (!resetn_in)
      sleeping |-> !sample_tick;
   endproperty
   a_sleep_no_sample: assert property (p_sleep_no_sample) else $error("Sampled while asleep");

endmodule

//--- verification/accel_power_mode_and_data_output_bench.sv
`timescale 1ns/1ps
module accel_power_mode_and_data_output_bench;
   import apmd_pkg::*;
   // ------------------------------------------------------------
   // Setup
   // ------------------------------------------------------------
   localparam int RAWP = 20;
   localparam int SLP = 10;
   localparam logic [7:0] SEL_T [6] = '{8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h40};
   localparam logic [7:0] CTL_T [6] = '{8'h00, 8'h80, 8'h80, 8'h20, 8'h40, 8'h40};
   localparam apmd_mode_t MODE_T [6] = '{APMD_NORMAL, APMD_STANDBY, APMD_SUSPEND, APMD_DEEP_SUSPEND,
                                         APMD_LOW_POWER1, APMD_LOW_POWER2};
   localparam logic [7:0] ACQ_M [6] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00};
   logic clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic access_busy_in = 1'b0;
   logic irq_hold_in = 1'b0;
   apmd_sample_t raw_sample_in = '0;
   apmd_sample_t filt_sample_in = '0;
   apmd_sample_t offset_in = '0;
   apmd_sample_t cur;
   apmd_sample_t held;
   apmd_req_t req;
   apmd_mode_t mode_out;
   logic [7:0] rdata_out;
   logic rvalid_out;
   logic acquiring_out;
   logic analog_on_out;
   logic [3:0] irq_pin_config_out;
   logic [1:0] watchdog_config_out;
   logic [31:0] rng = 32'h0000_0014;
   logic [7:0] exp_q[$];
   logic [7:0] msk_q[$];
   logic [13:0] d;
   int n_errors = 0;
   int n_tests = 0;
   int longest;

   always #2.5 clk_in = ~clk_in;

   apmd_host_model #(.WRITE_GAP(40)) u_host (.clk_in(clk_in), .mode_in(mode_out), .req_out(req));

   apmd_top #(.RAW_PERIOD(RAWP), .SLEEP_UNIT(SLP), .WAKE_SAMPLES(1)) dut (
      .clk_in(clk_in), .resetn_in(resetn_in), .req_in(req), .access_busy_in(access_busy_in),
      .irq_hold_in(irq_hold_in), .raw_sample_in(raw_sample_in), .filt_sample_in(filt_sample_in),
      .offset_in(offset_in), .rdata_out(rdata_out), .rvalid_out(rvalid_out), .analog_on_out(analog_on_out),
      .acquiring_out(acquiring_out), .mode_out(mode_out), .irq_pin_config_out(irq_pin_config_out),
      .watchdog_config_out(watchdog_config_out));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction

   task automatic check_val(input string name, input logic [7:0] exp, input logic [7:0] got,
                            input logic [7:0] mask);
      n_tests++;
      if ((got & mask) !== (exp & mask)) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp & mask, got & mask);
      end
   endtask

   task automatic chk_mode(input apmd_mode_t exp);
      check_val("mode", {5'h00, exp}, {5'h00, mode_out}, 8'hFF);
   endtask

   task automatic rd(input logic [7:0] addr, input logic [7:0] exp, input logic [7:0] mask);
      exp_q.push_back(exp);
      msk_q.push_back(mask);
      u_host.rd(addr);
   endtask

   // Holds inputs for several periods so the capture edge never matters
   task automatic new_sample(input logic use_raw);
      apmd_sample_t r;
      apmd_sample_t f;
      apmd_sample_t o;
      rng = xs(rng);
      r = {rng, rng[9:0]};
      rng = xs(rng);
      f = {rng, rng[9:0]};
      rng = xs(rng);
      o = {rng, rng[9:0]};
      @(negedge clk_in);
      raw_sample_in <= r;
      filt_sample_in <= f;
      offset_in <= o;
      cur.x = (use_raw ? r.x : f.x) + o.x;
      cur.y = (use_raw ? r.y : f.y) + o.y;
      cur.z = (use_raw ? r.z : f.z) + o.z;
      repeat (6 * RAWP) @(negedge clk_in);
   endtask

   task automatic low_run(input int cycles);
      int run;
      run = 0;
      longest = 0;
      repeat (cycles) begin
         @(negedge clk_in);
         run = (acquiring_out === 1'b1) ? 0 : run + 1;
         if (run > longest) longest = run;
      end
   endtask

   task automatic stop_test();
      $display("checks %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Sampled mid-cycle, where the registered read answer is settled
   always @(negedge clk_in) begin
      if (rvalid_out === 1'b1) begin
         if (exp_q.size() == 0) check_val("unexpected read", 8'h00, 8'hFF, 8'hFF);
         else check_val("read data", exp_q.pop_front(), rdata_out, msk_q.pop_front());
      end
   end

   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      repeat (2) @(posedge clk_in);
      @(negedge clk_in);
      resetn_in = 1'b1;
      @(negedge clk_in);
      check_val("acquiring", 8'h01, {7'h00, acquiring_out}, 8'hFF);
      chk_mode(APMD_NORMAL);
      rd(ADDR_FILTER_BANDWIDTH, RESET_FILTER_BANDWIDTH, 8'hFF);
      rd(ADDR_DATA_PATH_CONFIG, 8'h00, 8'hFF);
      for (int i = 0; i < 6; i++) begin
         u_host.wr(ADDR_LOW_POWER_SELECT, SEL_T[i]);
         u_host.wr(ADDR_LOW_POWER_CONTROL, CTL_T[i]);
         repeat (2) @(negedge clk_in);
         chk_mode(MODE_T[i]);
         check_val("acquiring", {7'h00, i == 0}, {7'h00, acquiring_out}, ACQ_M[i]);
         check_val("analog on", {7'h00, i == 0}, {7'h00, analog_on_out}, ACQ_M[i]);
         u_host.wr(ADDR_LOW_POWER_CONTROL, 8'h00);
         u_host.wr(ADDR_LOW_POWER_SELECT, 8'h00);
      end
      u_host.wr(ADDR_LOW_POWER_CONTROL, 8'h80);
      u_host.wr(ADDR_LOW_POWER_CONTROL, 8'hA0);
      repeat (2) @(negedge clk_in);
      chk_mode(APMD_SUSPEND);
      rd(ADDR_LOW_POWER_CONTROL, 8'h80, 8'hE0);
      u_host.wr(ADDR_LOW_POWER_CONTROL, 8'h00);
      for (int i = 1; i < 4; i++) begin
         u_host.wr(ADDR_FILTER_BANDWIDTH, 8'h0A);
         u_host.wr(ADDR_SERIAL_WATCHDOG_CONFIG, 8'h06);
         u_host.wr(ADDR_LOW_POWER_SELECT, SEL_T[i]);
         u_host.wr(ADDR_LOW_POWER_CONTROL, CTL_T[i]);
         u_host.wr(ADDR_IRQ_PIN_ELECTRICAL, 8'h05);
         repeat (2) @(negedge clk_in);
         check_val("pin config", 8'h05, {4'h0, irq_pin_config_out}, 8'hFF);
         check_val("watchdog", 8'h03, {6'h00, watchdog_config_out}, 8'hFF);
         rd(ADDR_FILTER_BANDWIDTH, (i == 3) ? RESET_FILTER_BANDWIDTH : 8'h0A, 8'h1F);
         u_host.wr(ADDR_SOFT_RESET_CMD, SOFT_RESET_KEY);
         repeat (2) @(negedge clk_in);
         chk_mode(APMD_NORMAL);
         rd(ADDR_FILTER_BANDWIDTH, RESET_FILTER_BANDWIDTH, 8'hFF);
         rd(ADDR_IRQ_PIN_ELECTRICAL, 8'h00, IRQ_PIN_MASK);
         rd(ADDR_SERIAL_WATCHDOG_CONFIG, 8'h00, WATCHDOG_MASK);
         rd(ADDR_SOFT_RESET_CMD, 8'h00, 8'hFF);
      end
      u_host.wr(ADDR_DATA_PATH_CONFIG, 8'h80);
      new_sample(1'b1);
      held = cur;
      u_host.wr(ADDR_LOW_POWER_SELECT, 8'h40);
      u_host.wr(ADDR_LOW_POWER_CONTROL, 8'h80);
      repeat (2) @(negedge clk_in);
      new_sample(1'b1); // ignored while acquisition is stopped
      for (int a = 0; a < 3; a++) begin
         d = held[41 - 14 * a -: 14];
         rd(ADDR_ACCEL_X_LOW + 8'(2 * a), {d[5:0], 2'b01}, 8'hFD);
         rd(ADDR_ACCEL_X_LOW + 8'(2 * a), {d[5:0], 2'b00}, 8'hFD);
         rd(ADDR_ACCEL_X_HIGH + 8'(2 * a), d[13:6], 8'hFF);
      end
      u_host.wr(ADDR_LOW_POWER_CONTROL, 8'h00);
      u_host.wr(ADDR_LOW_POWER_SELECT, 8'h00);
      for (int s = 0; s < 2; s++) begin
         u_host.wr(ADDR_DATA_PATH_CONFIG, s ? 8'hC0 : 8'h80);
         new_sample(1'b1);
         held = cur;
         rd(ADDR_ACCEL_Y_LOW, {held.y[5:0], 2'b00}, 8'hFC);
         new_sample(1'b1);
         rd(ADDR_ACCEL_Y_HIGH, s ? cur.y[13:6] : held.y[13:6], 8'hFF);
      end
      for (int b = 0; b < 3; b++) begin
         u_host.wr(ADDR_FILTER_BANDWIDTH, (b == 0) ? 8'h0F : ((b == 1) ? 8'h1F : 8'h0E));
         u_host.wr(ADDR_DATA_PATH_CONFIG, 8'h00);
         new_sample(1'b0);
         rd(ADDR_ACCEL_Z_HIGH, cur.z[13:6], 8'hFF);
      end
      for (int i = 4; i < 6; i++) begin
         u_host.wr(ADDR_LOW_POWER_SELECT, SEL_T[i]);
         u_host.wr(ADDR_LOW_POWER_CONTROL, (i == 4) ? 8'h4E : 8'h50);
         low_run(500);
         check_val("sleep length", (i == 4) ? 8'(4 * SLP) : 8'(8 * SLP), 8'(longest), 8'hFF);
         @(negedge clk_in);
         irq_hold_in <= (i == 4);
         access_busy_in <= (i == 5);
         repeat (100) @(negedge clk_in);
         low_run(200);
         check_val("held awake", 8'h00, 8'(longest), 8'hFF);
         irq_hold_in <= 1'b0;
         access_busy_in <= 1'b0;
         u_host.wr(ADDR_LOW_POWER_CONTROL, 8'h00);
         u_host.wr(ADDR_LOW_POWER_SELECT, 8'h00);
      end
      repeat (5) @(negedge clk_in);
      if (exp_q.size() != 0) check_val("pending reads", 8'h00, 8'(exp_q.size()), 8'hFF);
      stop_test();
   end
endmodule

//--- verification/apmd_host_model.sv
`timescale 1ns/1ps
module apmd_host_model
   import apmd_pkg::*;
#(
   parameter int WRITE_GAP = SUSPEND_WRITE_GAP_CYC
) (
   input wire logic clk_in,
   input wire apmd_mode_t mode_in,
   output apmd_req_t req_out
);
   // ------------------------------------------------------------
   // Register access host
   // ------------------------------------------------------------
   int since_wr = 0;

   initial req_out = '0;

   always @(posedge clk_in) begin
      since_wr <= req_out.write ? 0 : since_wr + 1;
   end

   // Suspend and low power 1 absorb writes slowly, so idle first
   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      int guard;
      guard = 0;
      // Mode output lags a write by one edge, so look only after an edge
      @(negedge clk_in);
      while ((mode_in === APMD_SUSPEND || mode_in === APMD_LOW_POWER1) && since_wr < WRITE_GAP
             && guard < WRITE_GAP + 2) begin
         @(negedge clk_in);
         guard++;
      end
      req_out <= '{1'b0, 1'b1, addr, data};
      @(negedge clk_in);
      req_out <= '0;
   endtask

   // Callers fetch an axis low byte before its high byte, except the bandwidth loop, which reads only the Z high byte
   task automatic rd(input logic [7:0] addr);
      @(negedge clk_in);
      req_out <= '{1'b1, 1'b0, addr, 8'h00};
      @(negedge clk_in);
      req_out <= '0;
   endtask
endmodule
